// [rtl/tcec_timer.sv]
// Purpose: 16-bit timer with capture and external event counting
// Assumes: Register port master never issues read and write together
// Notes: Status clear writes lose to a same-cycle event
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module tcec_timer (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Timer pins
  input wire logic primary_timer_input_i,
  input wire logic secondary_timer_input_i,
  // Interrupts
  output logic match_a_irq_o,
  output logic capture_b_irq_o,
  output logic irq_o
);
  typedef struct packed {
    logic [2:0] timer_mode_control;
    logic [7:0] prescaler_mode_reg;
    logic [15:0] main_count;
    logic [15:0] capture_compare_a;
    logic [15:0] capture_compare_b;
    logic [3:0] div_cnt;
    logic tick;
    logic [2:0] status;
    logic [2:0] irq_en;
    logic match_a;
    logic capt_b;
    logic [31:0] rdata;
  } tcec_state_s;
  tcec_state_s cur, next_cur;
  logic p_rise, p_fall, s_rise, s_fall;
  // True when the filtered edges match a two-bit edge code
  function automatic logic edge_hit(input logic [1:0] code, input logic r, input logic f);
    logic hit;
    hit = 1'b0;
    unique case (code)
      tcec_pkg::EDGE_FALL: hit = f;
      tcec_pkg::EDGE_RISE: hit = r;
      tcec_pkg::EDGE_BOTH: hit = r | f;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction
  // Filters sample on the count clock tick; in edge-clock mode use core rate
  wire logic [1:0] pin_vec;
  wire logic [1:0] rise_vec;
  wire logic [1:0] fall_vec;
  assign pin_vec = {secondary_timer_input_i, primary_timer_input_i};
  // Index 0 is the primary pin, index 1 the secondary pin
  for (genvar g = 0; g < 2; g++) begin : g_flt
    tcec_input_filter tcec_input_filter_i (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .pin_i(pin_vec[g]),
      .sample_i(cur.tick),
      .rise_o(rise_vec[g]),
      .fall_o(fall_vec[g])
    );
  end
  logic [1:0] cksel, pedge, sedge;
  logic p_valid, s_valid, p_opp, count_en;
  always_comb begin
    p_rise = rise_vec[0];
    p_fall = fall_vec[0];
    s_rise = rise_vec[1];
    s_fall = fall_vec[1];
    cksel = cur.prescaler_mode_reg[tcec_pkg::CKSEL_LSB +: 2];
    pedge = cur.prescaler_mode_reg[tcec_pkg::PEDGE_LSB +: 2];
    sedge = cur.prescaler_mode_reg[tcec_pkg::SEDGE_LSB +: 2];
    p_valid = edge_hit(pedge, p_rise, p_fall);
    s_valid = edge_hit(sedge, s_rise, s_fall);
    // Opposite edge exists only for a single-edge select
    p_opp = (pedge == tcec_pkg::EDGE_RISE) ? p_fall :
            (pedge == tcec_pkg::EDGE_FALL) ? p_rise : 1'b0;
    // Divided clock or the qualified primary edge advances the count
    count_en = (cksel == tcec_pkg::CK_EDGE) ? p_valid : cur.tick;
  end
  always_comb begin
    logic hw_capt_a;
    hw_capt_a = 1'b0;
    next_cur = cur;
    next_cur.div_cnt = cur.div_cnt + 4'h1;
    // Prescaler tick; edge-clock mode samples every core cycle
    unique case (cksel)
      tcec_pkg::CK_DIV2: next_cur.tick = cur.div_cnt[0];
      tcec_pkg::CK_DIV4: next_cur.tick = (cur.div_cnt[1:0] == 2'h3);
      tcec_pkg::CK_DIV16: next_cur.tick = (cur.div_cnt == 4'hF);
      tcec_pkg::CK_EDGE: next_cur.tick = 1'b1;
    endcase
    next_cur.match_a = 1'b0;
    next_cur.capt_b = 1'b0;
    next_cur.rdata = 32'h0000_0000;
    unique case (cur.timer_mode_control)
      tcec_pkg::MODE_STOP: begin
        next_cur.main_count = 16'h0000;
      end
      tcec_pkg::MODE_DUAL: begin
        if (count_en) begin
          next_cur.main_count = cur.main_count + 16'h0001;
        end
        if (p_valid) begin
          next_cur.capture_compare_b = cur.main_count;
          next_cur.capt_b = 1'b1;
        end
        if (s_valid) begin
          next_cur.capture_compare_a = cur.main_count;
          hw_capt_a = 1'b1;
          next_cur.match_a = 1'b1;
        end
      end
      tcec_pkg::MODE_TWOREG: begin
        if (count_en) begin
          next_cur.main_count = cur.main_count + 16'h0001;
        end
        if (p_valid) begin
          next_cur.capture_compare_b = cur.main_count;
          next_cur.capt_b = 1'b1;
        end
        if (p_opp) begin
          next_cur.capture_compare_a = cur.main_count;
          hw_capt_a = 1'b1;
        end
      end
      tcec_pkg::MODE_ONEREG: begin
        if (count_en) begin
          next_cur.main_count = cur.main_count + 16'h0001;
        end
        if (p_valid) begin
          next_cur.capture_compare_b = cur.main_count;
          next_cur.capt_b = 1'b1;
        end
      end
      tcec_pkg::MODE_RESTART: begin
        if (p_valid) begin
          // Capture first, then restart from zero
          next_cur.capture_compare_b = cur.main_count;
          next_cur.capt_b = 1'b1;
          next_cur.main_count = 16'h0000;
        end else if (count_en) begin
          next_cur.main_count = cur.main_count + 16'h0001;
        end
        if (p_opp) begin
          next_cur.capture_compare_a = cur.main_count;
          hw_capt_a = 1'b1;
        end
      end
      tcec_pkg::MODE_EVENT: begin
        // A zero compare would never fire usefully; the match is blocked while A is zero
        if (cur.main_count == cur.capture_compare_a && cur.capture_compare_a != 16'h0000) begin
          next_cur.main_count = 16'h0000;
          next_cur.match_a = 1'b1;
        end else if (p_valid) begin
          next_cur.main_count = cur.main_count + 16'h0001;
        end
      end
      default: begin
        next_cur.main_count = cur.main_count;
      end
    endcase
    // Register writes; compare register A is writable, B is capture only
    if (wr_i) begin
      unique case (addr_i)
        tcec_pkg::ADDR_MODE: next_cur.timer_mode_control = wdata_i[2:0];
        tcec_pkg::ADDR_PRESCALE: next_cur.prescaler_mode_reg = wdata_i[7:0];
        tcec_pkg::ADDR_CCA: next_cur.capture_compare_a = wdata_i[15:0];
        tcec_pkg::ADDR_IRQ_EN: next_cur.irq_en = wdata_i[2:0];
        default: next_cur.irq_en = cur.irq_en;
      endcase
    end
    if (wr_i && addr_i == tcec_pkg::ADDR_IRQ_CLR) begin
      next_cur.status = cur.status & ~wdata_i[2:0];
    end
    // Set after clear so a same-cycle event wins
    if (next_cur.match_a) begin
      next_cur.status[tcec_pkg::ST_MATCH_A] = 1'b1;
    end
    if (next_cur.capt_b) begin
      next_cur.status[tcec_pkg::ST_CAPT_B] = 1'b1;
    end
    // A capture of an unchanged value still counts as a capture
    if (hw_capt_a && !(wr_i && addr_i == tcec_pkg::ADDR_CCA)) begin
      next_cur.status[tcec_pkg::ST_CAPT_A] = 1'b1;
    end
    if (rd_i) begin
      unique case (addr_i)
        tcec_pkg::ADDR_MODE: next_cur.rdata = {29'h0, cur.timer_mode_control};
        tcec_pkg::ADDR_PRESCALE: next_cur.rdata = {24'h0, cur.prescaler_mode_reg};
        tcec_pkg::ADDR_COUNT: next_cur.rdata = {16'h0, cur.main_count};
        tcec_pkg::ADDR_CCA: next_cur.rdata = {16'h0, cur.capture_compare_a};
        tcec_pkg::ADDR_CCB: next_cur.rdata = {16'h0, cur.capture_compare_b};
        tcec_pkg::ADDR_STATUS: next_cur.rdata = {29'h0, cur.status};
        tcec_pkg::ADDR_IRQ_EN: next_cur.rdata = {29'h0, cur.irq_en};
        default: next_cur.rdata = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end
  assign rdata_o = cur.rdata;
  assign match_a_irq_o = cur.match_a;
  assign capture_b_irq_o = cur.capt_b;
  assign irq_o = |(cur.status & cur.irq_en);
endmodule
`default_nettype wire

// [include/tcec_pkg.sv]
// Purpose: Constants for the capture and event-counting timer block
// Assumes: 32-bit register port, one cycle read latency
// Notes: Register offsets are byte addresses of aligned words
//
// Overview of operation
// - Dual mode: primary edge captures count into B.
// - Dual mode: secondary edge captures count into A.
// - Each input: rising, falling or both edges.
// - Inputs need two equal count-clock samples first.
// - Two-register mode: opposite primary edge captures A.
// - Both-edge select in two-register mode: no A capture.
// - Restart mode: capture B, then clear count.
// - Both-edge select in restart mode: no A capture.
// - Event mode: each primary valid edge increments count.
// - Event mode: count equals nonzero A clears, raises match.
// - Event mode edges pass two-sample noise filter.
// - Edge code 00 fall, 01 rise, 11 both.
// - Count clock: divide 2, 4, 16, or edge.
package tcec_pkg;
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_PRESCALE = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;
  localparam logic [7:0] ADDR_CCA = 8'h0C;
  localparam logic [7:0] ADDR_CCB = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h18;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h1C;
  // Prescaler mode register fields
  localparam int CKSEL_LSB = 0;
  localparam int PEDGE_LSB = 4;
  localparam int SEDGE_LSB = 6;
  localparam logic [1:0] CK_DIV2 = 2'h0;
  localparam logic [1:0] CK_DIV4 = 2'h1;
  localparam logic [1:0] CK_DIV16 = 2'h2;
  localparam logic [1:0] CK_EDGE = 2'h3;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Timer mode control values
  localparam logic [2:0] MODE_STOP = 3'h0;
  localparam logic [2:0] MODE_DUAL = 3'h1;
  localparam logic [2:0] MODE_TWOREG = 3'h2;
  localparam logic [2:0] MODE_RESTART = 3'h3;
  localparam logic [2:0] MODE_EVENT = 3'h4;
  localparam logic [2:0] MODE_ONEREG = 3'h5;
  // Status bits
  localparam int ST_MATCH_A = 0;
  localparam int ST_CAPT_B = 1;
  localparam int ST_CAPT_A = 2;
  localparam logic [7:0] RESET_PRESCALE = 8'h00;
  localparam logic [2:0] RESET_MODE = 3'h0;
  localparam logic [15:0] RESET_CC = 16'h0000;
endpackage

// [rtl/tcec_input_filter.sv]
// Purpose: Synchronise a timer input and qualify it by two count-clock samples
// Assumes: sample_i is a one-cycle tick of the selected count clock
// Notes: Edge pulses are one core cycle long
`timescale 1ns/1ps
`default_nettype none
module tcec_input_filter (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Pin and sampling
  input wire logic pin_i,
  input wire logic sample_i,
  // Filtered edges
  output logic rise_o,
  output logic fall_o
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic smp;
    logic level;
    logic rise;
    logic fall;
  } tcec_flt_s;
  tcec_flt_s cur, next_cur;
  always_comb begin
    next_cur = cur;
    next_cur.sync1 = pin_i;
    next_cur.sync2 = cur.sync1;
    next_cur.rise = 1'b0;
    next_cur.fall = 1'b0;
    if (sample_i) begin
      next_cur.smp = cur.sync2;
      // Level only moves after two equal samples, so short glitches vanish
      if (cur.sync2 == cur.smp && cur.smp != cur.level) begin
        next_cur.level = cur.smp;
        next_cur.rise = cur.smp;
        next_cur.fall = ~cur.smp;
      end
    end
  end
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end
  assign rise_o = cur.rise;
  assign fall_o = cur.fall;
endmodule
`default_nettype wire

// [testbench/tcec_timer_props.sv]
// Purpose: Port checker for tcec_timer
// Assumes: Mode, enable and capture B status mirrored from bus traffic
// Notes: Quiet spans exceed the slowest filtered edge delay
`timescale 1ns/1ps
`default_nettype none
module tcec_timer_props (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // Pins and interrupts
  input wire logic primary_timer_input_i,
  input wire logic secondary_timer_input_i,
  input wire logic match_a_irq_o,
  input wire logic capture_b_irq_o,
  input wire logic irq_o
);
  logic [2:0] mode;
  logic [2:0] en;
  logic sb;
  logic [6:0] pq;
  logic [6:0] sq;
  wire logic no_a = mode != tcec_pkg::MODE_DUAL && mode != tcec_pkg::MODE_EVENT;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode <= 3'h0;
      en <= 3'h0;
      sb <= 1'b0;
      pq <= 7'h00;
      sq <= 7'h00;
    end else begin
      if (wr_i && addr_i == tcec_pkg::ADDR_MODE) mode <= wdata_i[2:0];
      if (wr_i && addr_i == tcec_pkg::ADDR_IRQ_EN) en <= wdata_i[2:0];
      // Status rises with the pulse, so a clear during the pulse removes it
      sb <= (sb || capture_b_irq_o) && !(wr_i && addr_i == tcec_pkg::ADDR_IRQ_CLR && wdata_i[1]);
      pq <= $stable(primary_timer_input_i) ? pq + {6'h00, pq != 7'h7F} : 7'h00;
      sq <= $stable(secondary_timer_input_i) ? sq + {6'h00, sq != 7'h7F} : 7'h00;
    end
  end
  default clocking dc @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);
  sequence s_st_rd;
    rd_i && addr_i == tcec_pkg::ADDR_STATUS && !capture_b_irq_o;
  endsequence
  sequence s_no_a;
    no_a [*4];
  endsequence
  AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data outside its slot");
  AST_CAPB_PULSE: assert property (capture_b_irq_o |=> !capture_b_irq_o)
    else $error("capture B pulse too long");
  AST_MATA_PULSE: assert property (match_a_irq_o |=> !match_a_irq_o)
    else $error("match A pulse too long");
  AST_STATUS_B: assert property (s_st_rd |=> rdata_o[tcec_pkg::ST_CAPT_B] == sb)
    else $error("capture B status wrong");
  AST_PRI_QUIET: assert property (pq >= 7'h3C |-> !capture_b_irq_o)
    else $error("capture without primary edge");
  AST_SEC_QUIET: assert property (mode == tcec_pkg::MODE_DUAL && sq >= 7'h3C && pq >= 7'h3C
    |-> !match_a_irq_o) else $error("match without secondary edge");
  AST_MATA_MODE: assert property (s_no_a |-> !match_a_irq_o)
    else $error("match A in wrong mode");
  AST_IRQ_LEVEL: assert property (capture_b_irq_o && en[1] |-> ##[0:2] irq_o)
    else $error("interrupt line not raised");
endmodule
bind tcec_timer tcec_timer_props tcec_timer_props_i (.core_clk_i, .resetn_i, .addr_i, .wdata_i,
  .wr_i, .rd_i, .rdata_o, .primary_timer_input_i, .secondary_timer_input_i, .match_a_irq_o,
  .capture_b_irq_o, .irq_o);
`default_nettype wire

// [testbench/tcec_pulse_src.sv]
// Purpose: External pulse sources on the two timer pins
// Assumes: Called from the bench process only
// Notes: Pins are plain push-pull levels
`timescale 1ns/1ps
`default_nettype none
module tcec_pulse_src (
  // Clock
  input wire logic core_clk_i,
  // Pins
  output logic pri_o,
  output logic sec_o
);
  initial begin
    pri_o = 1'b0;
    sec_o = 1'b0;
  end
  // New level just after an edge, then held n more cycles
  task automatic drive(input logic s, input logic l, input int n);
    @(posedge core_clk_i);
    if (s) sec_o <= l;
    else pri_o <= l;
    repeat (n) @(posedge core_clk_i);
  endtask
endmodule
`default_nettype wire

// [testbench/tcec_timer_bench.sv]
// Purpose: Self-checking bench for tcec_timer
// Assumes: Pins rest low between scenarios
// Notes: A full count wrap is too long to reach here
`timescale 1ns/1ps
`default_nettype none
module tcec_timer_bench;
  logic core_clk_i;
  logic resetn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic pri;
  logic sec;
  logic mat;
  logic capb;
  logic irq;
  logic [31:0] d;
  logic [31:0] e;
  int failures = 0;
  int tests_run = 0;
  int na;
  int nb;
  tcec_timer tcec_timer_i (.core_clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .primary_timer_input_i(pri), .secondary_timer_input_i(sec), .match_a_irq_o(mat),
    .capture_b_irq_o(capb), .irq_o(irq));
  tcec_pulse_src tcec_pulse_src_i (.core_clk_i, .pri_o(pri), .sec_o(sec));
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  always @(negedge core_clk_i) begin
    na += int'(mat === 1'b1);
    nb += int'(capb === 1'b1);
  end
  task automatic c(input logic ok, input string s);
    tests_run++;
    if (ok !== 1'b1) begin
      failures++;
      $display("Error %0t: %s", $time, s);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] v);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic r(input logic [7:0] a);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    @(negedge core_clk_i);
    d = rdata_o;
    @(posedge core_clk_i);
  endtask
  task automatic pd(input logic s, input logic l, input int n);
    tcec_pulse_src_i.drive(s, l, n);
  endtask
  task automatic m(input logic [2:0] md, input logic [7:0] pr);
    w(tcec_pkg::ADDR_MODE, 32'h0);
    w(tcec_pkg::ADDR_PRESCALE, {24'h0, pr});
    w(tcec_pkg::ADDR_MODE, {29'h0, md});
    na = 0;
    nb = 0;
  endtask
  task automatic ci(input logic v, input string s);
    repeat (2) @(negedge core_clk_i);
    c(irq === v, s);
    @(posedge core_clk_i);
  endtask
  task automatic t_reset();
    for (int k = 0; k < 9; k++) begin
      if (k != 7) begin
        r(8'(4 * k));
        c(d === 32'h0, "reset value");
      end
    end
  endtask
  task automatic t_clock();
    logic [15:0] c0;
    int q;
    for (int k = 0; k < 3; k++) begin
      m(tcec_pkg::MODE_DUAL, 8'(k));
      r(tcec_pkg::ADDR_COUNT);
      c0 = d[15:0];
      repeat (62) @(posedge core_clk_i);
      r(tcec_pkg::ADDR_COUNT);
      q = (k == 2) ? 4 : 32 >> k;
      c(d[15:0] - c0 >= 16'(q - 1) && d[15:0] - c0 <= 16'(q + 1), "count rate");
    end
  endtask
  task automatic t_dual();
    logic [1:0] cd [3] = '{tcec_pkg::EDGE_FALL, tcec_pkg::EDGE_RISE, tcec_pkg::EDGE_BOTH};
    for (int k = 0; k < 3; k++) begin
      m(tcec_pkg::MODE_DUAL, {cd[k], cd[k], 4'h0});
      for (int s = 0; s < 2; s++) begin
        pd(s[0], 1'b1, 48);
        pd(s[0], 1'b0, 48);
      end
      c(nb === (k == 2 ? 2 : 1), "primary captures");
      c(na === (k == 2 ? 2 : 1), "secondary captures");
      r(tcec_pkg::ADDR_CCB);
      e = d;
      r(tcec_pkg::ADDR_CCA);
      c(e[15:0] !== 16'h0 && d[15:0] > e[15:0], "captured counts");
    end
  endtask
  task automatic t_noise();
    m(tcec_pkg::MODE_DUAL, 8'h12);
    pd(1'b0, 1'b1, 3);
    pd(1'b0, 1'b0, 48);
    c(nb === 0, "short pulse captured");
    m(tcec_pkg::MODE_EVENT, 8'h13);
    pd(1'b0, 1'b1, 0);
    pd(1'b0, 1'b0, 16);
    r(tcec_pkg::ADDR_COUNT);
    c(d === 32'h0, "short pulse counted");
  endtask
  task automatic t_tworeg();
    for (int k = 0; k < 3; k++) begin
      m((k == 2) ? tcec_pkg::MODE_ONEREG : tcec_pkg::MODE_TWOREG, (k == 1) ? 8'h30 : 8'h10);
      w(tcec_pkg::ADDR_CCA, 32'hFFFF);
      pd(1'b0, 1'b1, 48);
      pd(1'b0, 1'b0, 48);
      r(tcec_pkg::ADDR_CCB);
      e = d;
      r(tcec_pkg::ADDR_CCA);
      c(nb === ((k == 1) ? 2 : 1) && e[15:0] !== 16'h0, "primary capture");
      c((d === 32'hFFFF) === (k != 0), "reverse edge capture");
    end
  endtask
  task automatic t_restart();
    m(tcec_pkg::MODE_RESTART, 8'h10);
    repeat (100) @(posedge core_clk_i);
    pd(1'b0, 1'b1, 48);
    r(tcec_pkg::ADDR_CCB);
    e = d;
    r(tcec_pkg::ADDR_COUNT);
    c(nb === 1 && e[15:0] > 16'h0032, "capture before clear");
    c(d[15:0] < 16'h0020, "count restarted");
    pd(1'b0, 1'b0, 8);
  endtask
  task automatic t_event();
    m(tcec_pkg::MODE_EVENT, 8'h13);
    w(tcec_pkg::ADDR_CCA, 32'h3);
    w(tcec_pkg::ADDR_IRQ_CLR, 32'h1);
    for (int k = 1; k < 4; k++) begin
      pd(1'b0, 1'b1, 8);
      pd(1'b0, 1'b0, 8);
      r(tcec_pkg::ADDR_COUNT);
      c(d === 32'(k % 3), "event count");
    end
    c(na === 1, "compare match");
    r(tcec_pkg::ADDR_STATUS);
    c(d[tcec_pkg::ST_MATCH_A] === 1'b1, "match status");
  endtask
  task automatic t_irq();
    w(tcec_pkg::ADDR_IRQ_CLR, 32'h7);
    r(tcec_pkg::ADDR_STATUS);
    c(d === 32'h0, "status cleared");
    w(tcec_pkg::ADDR_IRQ_EN, 32'h2);
    m(tcec_pkg::MODE_DUAL, 8'h10);
    pd(1'b0, 1'b1, 48);
    ci(1'b1, "irq raised");
    r(tcec_pkg::ADDR_STATUS);
    c(d[tcec_pkg::ST_CAPT_B] === 1'b1, "capture status");
    w(tcec_pkg::ADDR_IRQ_EN, 32'h1);
    ci(1'b0, "irq masked");
    w(tcec_pkg::ADDR_IRQ_EN, 32'h2);
    w(tcec_pkg::ADDR_IRQ_CLR, 32'h2);
    ci(1'b0, "irq cleared");
    w(8'h20, 32'h5A);
    r(8'h20);
    c(d === 32'h0, "unmapped read");
    pd(1'b0, 1'b0, 8);
  endtask
  task automatic give_verdict();
    $display("Checks %0d, errors %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    @(posedge core_clk_i);
    t_reset();
    t_clock();
    t_dual();
    t_noise();
    t_tworeg();
    t_restart();
    t_event();
    t_irq();
    give_verdict();
  end
  // Whole run is under two thousand cycles; this span is far beyond it
  initial begin
    #100us;
    failures++;
    $display("Error %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule
`default_nettype wire
